// ==== pkg/io_bus_pkg.sv ====
// Constants and carrier types for the processor-side I/O bus interface.
package io_bus_pkg;

	// ********************************
	// Timing
	// ********************************
	localparam int CLK_NS = 10;
	localparam int MEM_CYCLE_NS = 400;
	localparam int RQ_ACTIVE_NS = 200;
	localparam int SEL_SETUP_NS = 100;
	localparam int STROBE_NS = 200;
	localparam int PULSE_NS = 100;
	localparam int ACK_NS = 200;
	localparam int TICK_W = 6;
	typedef logic [TICK_W-1:0] tick_t;
	localparam tick_t MEM_CYC = tick_t'(MEM_CYCLE_NS / CLK_NS);
	localparam tick_t RQ_START = tick_t'((MEM_CYCLE_NS - RQ_ACTIVE_NS) / CLK_NS);
	localparam tick_t SEL_CYC = tick_t'((SEL_SETUP_NS + CLK_NS - 1) / CLK_NS);
	localparam tick_t STROBE_CYC = tick_t'((STROBE_NS + CLK_NS - 1) / CLK_NS);
	localparam tick_t PULSE_CYC = tick_t'((PULSE_NS + CLK_NS - 1) / CLK_NS);
	localparam tick_t ACK_CYC = tick_t'((ACK_NS + CLK_NS - 1) / CLK_NS);

	// ********************************
	// Codes and fields
	// ********************************
	localparam logic [1:0] CTRL_NONE = 2'h0;
	localparam logic [1:0] CTRL_START = 2'h1;
	localparam logic [1:0] CTRL_CLEAR = 2'h2;
	localparam logic [1:0] CTRL_PULSE = 2'h3;
	localparam int NUM_BUF = 3;
	localparam int DEV_LSB = 0;
	localparam int DEV_W = 6;
	localparam logic [15:0] IRQ_SAVE_ADDR = 16'h0000;
	localparam logic [15:0] IRQ_VECTOR_ADDR = 16'h0001;

	// ********************************
	// Carriers
	// ********************************
	typedef struct packed {
		logic out_dir;
		logic [1:0] buf_sel;
		logic [1:0] ctrl;
		logic [15:0] instr;
		logic [15:0] acc;
	} pio_cmd_t;

	typedef struct packed {
		logic we;
		logic [15:0] addr;
		logic [15:0] wdata;
	} mem_req_t;

	typedef struct packed {
		logic irq_n;
		logic chan_n;
	} bus_req_t;

endpackage

// ==== hdl/io_bus_cpu_interface.sv ====
// Processor-side I/O bus sequencer: programmed I/O, interrupts, data channel.
`timescale 1ns/1ps
// Summary of operation
// - Processor asserts channel ack; prioritised controller drives memory address.
// - Input channel transfer: data-in strobe while controller drives data.
// - Output channel transfer: data-out strobe while memory word is driven.
// - Self-test select low during program load loads self-test program.
// - Device code driven first; only matching controller answers strobes.
// - Data-in strobe per buffer; data latched into accumulator at strobe end.
// - After the data phase, one start, clear or device pulse if asked.
// - Data-out: accumulator driven first, then buffer data-out strobe.
// - Request-sync strobe generated at the end of every memory cycle.
// - Request-sync period 400ns: 200ns inactive, 200ns active.
// - Interrupt request sampled about 100ns before instruction end.
// - Taken interrupt: two memory cycles save PC at 0, jump via 1.
// - Control field 01 start, 10 clear, 11 device pulse.
// - Device select carries instruction bits 0-5, first line most significant.
module io_bus_cpu_interface
	import io_bus_pkg::*;
(
	// Clocks and reset
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic link_clk_i,
	// Programmed I/O command port
	input wire logic cmd_valid_i,
	input wire pio_cmd_t cmd_i,
	output logic cmd_ready_o,
	output logic pio_done_o,
	output logic [15:0] pio_rdata_o,
	// Interrupt entry and program load
	input wire logic instr_end_soon_i,
	input wire logic [15:0] pc_i,
	output logic irq_take_o,
	output logic vector_valid_o,
	output logic [15:0] vector_o,
	input wire logic load_start_i,
	output logic load_selftest_o,
	// Memory port
	output logic mem_valid_o,
	output mem_req_t mem_o,
	input wire logic mem_done_i,
	input wire logic [15:0] mem_rdata_i,
	// I/O bus data and select
	input wire logic [15:0] data_i,
	output logic [15:0] data_o,
	output logic data_oe_o,
	output logic [DEV_W-1:0] device_select_o,
	// I/O bus strobes
	output logic data_in_strobe_a_o,
	output logic data_in_strobe_b_o,
	output logic data_in_strobe_c_o,
	output logic data_out_strobe_a_o,
	output logic data_out_strobe_b_o,
	output logic data_out_strobe_c_o,
	output logic start_pulse_o,
	output logic clear_pulse_o,
	output logic device_pulse_o,
	output logic request_sync_n_o,
	// I/O bus requests and data channel
	input wire logic irq_request_n_i,
	input wire logic channel_request_n_i,
	output logic channel_ack_n_o,
	input wire logic channel_direction_n_i,
	output logic channel_data_in_strobe_o,
	output logic channel_data_out_strobe_o,
	input wire logic selftest_select_n_i
);

	typedef enum logic [10:0] {
		S_IDLE = 11'h001,
		S_PIO_SEL = 11'h002,
		S_PIO_STB = 11'h004,
		S_PIO_CTL = 11'h008,
		S_CH_ACK = 11'h010,
		S_CH_IN = 11'h020,
		S_CH_WR = 11'h040,
		S_CH_RD = 11'h080,
		S_CH_OUT = 11'h100,
		S_IRQ_SAVE = 11'h200,
		S_IRQ_FETCH = 11'h400
	} state_t;

	state_t state;
	state_t next_state;
	tick_t tmr;
	tick_t next_tmr;
	tick_t mem_tick;
	tick_t next_mem_tick;
	logic mem_end;
	bus_req_t lk_meta;
	bus_req_t lk_req;
	bus_req_t x_meta;
	bus_req_t req_s;
	logic [17:0] pin_meta;
	logic [17:0] pin_s;
	logic [15:0] data_s;
	logic dir_s;
	logic sel_s;
	pio_cmd_t cmd_q;
	logic cmd_pend;
	logic irq_pend;
	logic [15:0] chan_addr;
	logic [NUM_BUF-1:0] din_stb;
	logic [NUM_BUF-1:0] dout_stb;
	logic pio_state;

	// ********************************
	// Link side and synchronisers
	// ********************************
	// Requests only move on request-sync edges, so the link sampler is a
	// plain level capture; its result is a level and crosses by two flops.
	always_ff @(posedge link_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			lk_meta <= '1;
			lk_req <= '1;
		end else begin
			lk_meta <= {irq_request_n_i, channel_request_n_i};
			lk_req <= lk_meta;
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			x_meta <= '1;
			req_s <= '1;
			pin_meta <= '1;
			pin_s <= '1;
		end else begin
			x_meta <= lk_req;
			req_s <= x_meta;
			pin_meta <= {data_i, channel_direction_n_i, selftest_select_n_i};
			pin_s <= pin_meta;
		end
	end

	assign data_s = pin_s[17:2];
	assign dir_s = pin_s[1];
	assign sel_s = pin_s[0];

	// ********************************
	// Memory cycle timing
	// ********************************
	always_comb begin
		next_mem_tick = tick_t'(mem_tick + 1'b1);
		if (mem_end) begin
			next_mem_tick = '0;
		end
	end

	assign mem_end = (mem_tick == tick_t'(MEM_CYC - 1'b1));

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mem_tick <= '0;
			request_sync_n_o <= 1'b1;
		end else begin
			mem_tick <= next_mem_tick;
			request_sync_n_o <= (next_mem_tick < RQ_START);
		end
	end

	// ********************************
	// Sequencer
	// ********************************
	// A channel request wins over interrupt entry, which wins over a
	// pending programmed transfer; all start on a memory cycle boundary.
	always_comb begin
		next_state = state;
		next_tmr = (tmr == '0) ? tmr : tick_t'(tmr - 1'b1);
		case (state)
			S_IDLE: begin
				if (mem_end) begin
					if (!req_s.chan_n) begin
						next_state = S_CH_ACK;
						next_tmr = tick_t'(ACK_CYC - 1'b1);
					end else if (irq_pend) begin
						next_state = S_IRQ_SAVE;
					end else if (cmd_pend) begin
						next_state = S_PIO_SEL;
						next_tmr = tick_t'(SEL_CYC - 1'b1);
					end
				end
			end
			S_PIO_SEL: begin
				if (tmr == '0) begin
					next_state = S_PIO_STB;
					next_tmr = tick_t'(STROBE_CYC - 1'b1);
				end
			end
			S_PIO_STB: begin
				if (tmr == '0) begin
					next_state = S_IDLE;
					if (cmd_q.ctrl != CTRL_NONE) begin
						next_state = S_PIO_CTL;
						next_tmr = tick_t'(PULSE_CYC - 1'b1);
					end
				end
			end
			S_PIO_CTL: begin
				if (tmr == '0) begin
					next_state = S_IDLE;
				end
			end
			S_CH_ACK: begin
				if (tmr == '0) begin
					next_state = S_CH_IN;
					next_tmr = tick_t'(STROBE_CYC - 1'b1);
					if (dir_s) begin
						next_state = S_CH_RD;
					end
				end
			end
			S_CH_IN: begin
				if (tmr == '0) begin
					next_state = S_CH_WR;
				end
			end
			S_CH_RD: begin
				if (mem_done_i) begin
					next_state = S_CH_OUT;
					next_tmr = tick_t'(STROBE_CYC - 1'b1);
				end
			end
			S_CH_WR, S_IRQ_FETCH: begin
				if (mem_done_i) begin
					next_state = S_IDLE;
				end
			end
			S_CH_OUT: begin
				if (tmr == '0) begin
					next_state = S_IDLE;
				end
			end
			S_IRQ_SAVE: begin
				if (mem_done_i) begin
					next_state = S_IRQ_FETCH;
				end
			end
			default: begin
				next_state = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= S_IDLE;
			tmr <= '0;
		end else begin
			state <= next_state;
			tmr <= next_tmr;
		end
	end

	// ********************************
	// Bus drivers
	// ********************************
	assign pio_state = (next_state == S_PIO_SEL) || (next_state == S_PIO_STB) ||
		(next_state == S_PIO_CTL);

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			device_select_o <= '0;
			data_o <= '0;
			data_oe_o <= 1'b0;
			start_pulse_o <= 1'b0;
			clear_pulse_o <= 1'b0;
			device_pulse_o <= 1'b0;
			channel_ack_n_o <= 1'b1;
			channel_data_in_strobe_o <= 1'b0;
			channel_data_out_strobe_o <= 1'b0;
		end else begin
			device_select_o <= pio_state ? cmd_q.instr[DEV_LSB +: DEV_W] : '0;
			data_oe_o <= (pio_state && cmd_q.out_dir) || (next_state == S_CH_OUT);
			if (state == S_CH_RD) begin
				data_o <= mem_rdata_i;
			end else if (pio_state && cmd_q.out_dir) begin
				data_o <= cmd_q.acc;
			end
			start_pulse_o <= (next_state == S_PIO_CTL) && (cmd_q.ctrl == CTRL_START);
			clear_pulse_o <= (next_state == S_PIO_CTL) && (cmd_q.ctrl == CTRL_CLEAR);
			device_pulse_o <= (next_state == S_PIO_CTL) && (cmd_q.ctrl == CTRL_PULSE);
			channel_ack_n_o <= (next_state != S_CH_ACK);
			channel_data_in_strobe_o <= (next_state == S_CH_IN);
			channel_data_out_strobe_o <= (next_state == S_CH_OUT);
		end
	end

	generate
		for (genvar i = 0; i < NUM_BUF; i++) begin : g_buf
			always_ff @(posedge clock_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					din_stb[i] <= 1'b0;
					dout_stb[i] <= 1'b0;
				end else begin
					din_stb[i] <= (next_state == S_PIO_STB) && !cmd_q.out_dir &&
						(cmd_q.buf_sel == 2'(i));
					dout_stb[i] <= (next_state == S_PIO_STB) && cmd_q.out_dir &&
						(cmd_q.buf_sel == 2'(i));
				end
			end
		end
	endgenerate

	assign data_in_strobe_a_o = din_stb[0];
	assign data_in_strobe_b_o = din_stb[1];
	assign data_in_strobe_c_o = din_stb[2];
	assign data_out_strobe_a_o = dout_stb[0];
	assign data_out_strobe_b_o = dout_stb[1];
	assign data_out_strobe_c_o = dout_stb[2];

	// ********************************
	// Command port
	// ********************************
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cmd_q <= '0;
			cmd_pend <= 1'b0;
			cmd_ready_o <= 1'b1;
			pio_done_o <= 1'b0;
			pio_rdata_o <= '0;
		end else begin
			pio_done_o <= 1'b0;
			if (cmd_valid_i && cmd_ready_o) begin
				cmd_q <= cmd_i;
				cmd_pend <= 1'b1;
				cmd_ready_o <= 1'b0;
			end
			if (state == S_IDLE && next_state == S_PIO_SEL) begin
				cmd_pend <= 1'b0;
			end
			if (state == S_PIO_STB && tmr == '0 && !cmd_q.out_dir) begin
				pio_rdata_o <= data_s;
			end
			if (pio_state == 1'b0 && (state == S_PIO_STB || state == S_PIO_CTL)) begin
				pio_done_o <= 1'b1;
				cmd_ready_o <= 1'b1;
			end
		end
	end

	// ********************************
	// Interrupt entry, memory port, load
	// ********************************
	// A sample in the same cycle as the entry wins, so no request is lost.
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_pend <= 1'b0;
			irq_take_o <= 1'b0;
			vector_valid_o <= 1'b0;
			vector_o <= '0;
			load_selftest_o <= 1'b0;
		end else begin
			irq_take_o <= (state == S_IDLE) && (next_state == S_IRQ_SAVE);
			if (instr_end_soon_i && !req_s.irq_n) begin
				irq_pend <= 1'b1;
			end else if (state == S_IDLE && next_state == S_IRQ_SAVE) begin
				irq_pend <= 1'b0;
			end
			vector_valid_o <= (state == S_IRQ_FETCH) && mem_done_i;
			if (state == S_IRQ_FETCH && mem_done_i) begin
				vector_o <= mem_rdata_i;
			end
			if (load_start_i) begin
				load_selftest_o <= !sel_s;
			end
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			chan_addr <= '0;
			mem_valid_o <= 1'b0;
			mem_o <= '0;
		end else begin
			mem_valid_o <= (next_state != state) && ((next_state == S_CH_WR) ||
				(next_state == S_CH_RD) || (next_state == S_IRQ_SAVE) ||
				(next_state == S_IRQ_FETCH));
			if (state == S_CH_ACK && tmr == '0) begin
				chan_addr <= data_s;
				mem_o <= '{we: 1'b0, addr: data_s, wdata: '0};
			end
			if (state == S_CH_IN && tmr == '0) begin
				mem_o <= '{we: 1'b1, addr: chan_addr, wdata: data_s};
			end
			if (state == S_IDLE && next_state == S_IRQ_SAVE) begin
				mem_o <= '{we: 1'b1, addr: IRQ_SAVE_ADDR, wdata: pc_i};
			end
			if (state == S_IRQ_SAVE && mem_done_i) begin
				mem_o <= '{we: 1'b0, addr: IRQ_VECTOR_ADDR, wdata: '0};
			end
		end
	end

	// ********************************
	// Assertions
	// ********************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);

	logic pio_any;
	assign pio_any = |{din_stb, dout_stb};

	sequence s_ctrl_phase;
		(start_pulse_o || clear_pulse_o || device_pulse_o) [*8];
	endsequence

	property p_rq_active;
		$fell(request_sync_n_o) |-> ##20 $rose(request_sync_n_o);
	endproperty
	a_rq_active: assert property (p_rq_active) else $error("sync active length");
	property p_rq_idle;
		$rose(request_sync_n_o) |-> ##20 $fell(request_sync_n_o);
	endproperty
	a_rq_idle: assert property (p_rq_idle) else $error("sync idle length");
	property p_ack;
		$fell(channel_ack_n_o) |-> ##20 $rose(channel_ack_n_o);
	endproperty
	a_ack: assert property (p_ack) else $error("channel ack length");
	property p_select;
		pio_any |-> device_select_o == cmd_q.instr[DEV_LSB +: DEV_W];
	endproperty
	a_select: assert property (p_select) else $error("select not held");
	property p_din_latch;
		$fell(|din_stb) |-> pio_rdata_o == $past(data_s);
	endproperty
	a_din_latch: assert property (p_din_latch) else $error("data in not latched");
	property p_dout;
		|dout_stb |-> data_oe_o && data_o == cmd_q.acc;
	endproperty
	a_dout: assert property (p_dout) else $error("data out not driven");
	property p_ctrl;
		$fell(pio_any) && cmd_q.ctrl != CTRL_NONE |-> s_ctrl_phase;
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("control pulse missing");
	property p_ctrl_code;
		start_pulse_o |-> cmd_q.ctrl == CTRL_START && !pio_any;
	endproperty
	a_ctrl_code: assert property (p_ctrl_code) else $error("wrong pulse");
	property p_ch_in;
		channel_data_in_strobe_o |-> !data_oe_o;
	endproperty
	a_ch_in: assert property (p_ch_in) else $error("bus driven on input");
	property p_ch_out;
		channel_data_out_strobe_o |-> data_oe_o;
	endproperty
	a_ch_out: assert property (p_ch_out) else $error("bus idle on output");
	property p_irq;
		irq_take_o |-> mem_valid_o && mem_o.we && mem_o.addr == IRQ_SAVE_ADDR;
	endproperty
	a_irq: assert property (p_irq) else $error("pc not saved at 0");
	property p_selftest;
		load_start_i && !sel_s |=> load_selftest_o;
	endproperty
	a_selftest: assert property (p_selftest) else $error("self-test missed");

endmodule

// ==== tb/io_bus_periph_model.sv ====
// Peripheral controller model for the far side of the I/O bus.
`timescale 1ns/1ps
module io_bus_periph_model
	import io_bus_pkg::*;
#(
	parameter logic [DEV_W-1:0] DEV_CODE = 6'h2D
)(
	// Clock and test controls
	input wire logic clock_i,
	input wire logic want_irq_i,
	input wire logic want_chan_i,
	input wire logic chan_out_i,
	input wire logic [15:0] chan_word_i,
	// Bus from the processor
	input wire logic [15:0] bus_data_i,
	input wire logic bus_oe_i,
	input wire logic [DEV_W-1:0] select_i,
	input wire logic [2:0] din_stb_i,
	input wire logic [2:0] dout_stb_i,
	input wire logic [2:0] pulse_i,
	input wire logic rq_sync_n_i,
	input wire logic ack_n_i,
	input wire logic cdin_i,
	input wire logic cdout_i,
	// Bus to the processor and observations
	output logic [15:0] data_o,
	output logic irq_n_o,
	output logic chan_req_n_o,
	output logic chan_dir_n_o,
	output logic [DEV_W-1:0] seen_sel_o,
	output logic [3:0] seen_kind_o,
	output logic [2:0] seen_pulse_o,
	output logic [15:0] got_word_o,
	output logic [15:0] got_chan_o
);
	// **********************************
	// Bus behaviour
	// **********************************
	// A released bus shows the inverse of its last level, never a hold.
	logic [15:0] idle = 16'h5A5A;
	logic [15:0] drv_val;
	logic drv;
	logic acked = 1'b0;
	logic [2:0] stb_q = 3'h0;
	logic mine;
	assign mine = (select_i === DEV_CODE);
	assign data_o = bus_oe_i ? bus_data_i : (drv ? drv_val : idle);
	// Sole board with its priority input tied active.
	assign chan_dir_n_o = !ack_n_i ? chan_out_i : !chan_out_i;
	initial begin
		irq_n_o = 1'b1;
		chan_req_n_o = 1'b1;
	end
	always_comb begin
		drv = 1'b0;
		drv_val = ack_n_i ? ~chan_word_i : chan_word_i;
		if (mine && din_stb_i != 3'h0) begin
			drv = 1'b1;
			drv_val = 16'hC3A0 | {14'h0, din_stb_i[2], din_stb_i[1]};
		end
		// The owner keeps its word up for the whole in strobe, although
		// its request has already dropped at the next request sync.
		if ((!ack_n_i && !chan_req_n_o) ||
			(cdin_i && acked)) begin
			drv = 1'b1;
		end
	end
	// Requests move only at the leading edge of request sync.
	always @(negedge rq_sync_n_i) begin
		irq_n_o <= !want_irq_i;
		chan_req_n_o <= !(want_chan_i && !acked);
	end
	always @(posedge clock_i) begin
		idle <= ~data_o;
		if (ack_n_i === 1'b0 && chan_req_n_o === 1'b0)
			acked <= 1'b1;
		else if (!want_chan_i && ack_n_i === 1'b1 && cdin_i === 1'b0)
			acked <= 1'b0;
		stb_q <= din_stb_i | dout_stb_i;
		if ((din_stb_i | dout_stb_i) != 3'h0 && stb_q == 3'h0) begin
			seen_sel_o <= select_i;
			seen_kind_o <= {dout_stb_i != 3'h0, din_stb_i | dout_stb_i};
			seen_pulse_o <= 3'h0;
		end else begin
			seen_pulse_o <= seen_pulse_o | pulse_i;
		end
		if (dout_stb_i != 3'h0 && mine)
			got_word_o <= bus_oe_i ? bus_data_i : 16'hXXXX;
		if (cdout_i)
			got_chan_o <= bus_oe_i ? bus_data_i : 16'hXXXX;
	end
endmodule

// ==== tb/io_bus_cpu_interface_tb.sv ====
// Self-checking bench for the processor-side I/O bus sequencer.
`timescale 1ns/1ps
module io_bus_cpu_interface_tb;
	import io_bus_pkg::*;
	localparam logic [5:0] DEV = 6'h2D;
	logic clock_i = 1'b0;
	logic link_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic cmd_valid_i = 1'b0;
	pio_cmd_t cmd_i = '0;
	logic instr_end_soon_i = 1'b0;
	logic [15:0] pc_i = 16'h0000;
	logic load_start_i = 1'b0;
	logic selftest_select_n_i = 1'b1;
	logic mem_done_i = 1'b0;
	logic [15:0] mem_rdata_i = 16'h0000;
	logic want_irq = 1'b0, want_chan = 1'b0, chan_out = 1'b0;
	logic [15:0] chan_word = 16'h0000;
	logic cmd_ready_o, pio_done_o, irq_take_o, vector_valid_o;
	logic load_selftest_o, mem_valid_o, data_oe_o, request_sync_n_o;
	logic [15:0] pio_rdata_o, vector_o, data_i, data_o, got_word, got_chan;
	mem_req_t mem_o;
	logic [5:0] device_select_o, seen_sel;
	logic [2:0] din, dout, pulse, seen_pulse;
	logic [3:0] seen_kind;
	logic irq_request_n_i, channel_request_n_i, channel_ack_n_o;
	logic channel_direction_n_i, cdin, cdout;
	int fail_count = 0;
	int checked = 0;
	mem_req_t mem_log[$];

	always #5 clock_i = ~clock_i;
	initial begin
		#3.3;
		forever #80 link_clk_i = ~link_clk_i;
	end

	io_bus_cpu_interface i_dut (
		.clock_i, .arst_n_i, .link_clk_i, .cmd_valid_i, .cmd_i, .cmd_ready_o,
		.pio_done_o, .pio_rdata_o, .instr_end_soon_i, .pc_i, .irq_take_o,
		.vector_valid_o, .vector_o, .load_start_i, .load_selftest_o,
		.mem_valid_o, .mem_o, .mem_done_i, .mem_rdata_i, .data_i, .data_o,
		.data_oe_o, .device_select_o,
		.data_in_strobe_a_o(din[0]), .data_in_strobe_b_o(din[1]),
		.data_in_strobe_c_o(din[2]), .data_out_strobe_a_o(dout[0]),
		.data_out_strobe_b_o(dout[1]), .data_out_strobe_c_o(dout[2]),
		.start_pulse_o(pulse[0]), .clear_pulse_o(pulse[1]),
		.device_pulse_o(pulse[2]), .request_sync_n_o, .irq_request_n_i,
		.channel_request_n_i, .channel_ack_n_o, .channel_direction_n_i,
		.channel_data_in_strobe_o(cdin), .channel_data_out_strobe_o(cdout),
		.selftest_select_n_i
	);

	io_bus_periph_model #(.DEV_CODE(DEV)) i_periph (
		.clock_i, .want_irq_i(want_irq), .want_chan_i(want_chan),
		.chan_out_i(chan_out), .chan_word_i(chan_word), .bus_data_i(data_o),
		.bus_oe_i(data_oe_o), .select_i(device_select_o), .din_stb_i(din),
		.dout_stb_i(dout), .pulse_i(pulse), .rq_sync_n_i(request_sync_n_o),
		.ack_n_i(channel_ack_n_o), .cdin_i(cdin), .cdout_i(cdout),
		.data_o(data_i), .irq_n_o(irq_request_n_i),
		.chan_req_n_o(channel_request_n_i),
		.chan_dir_n_o(channel_direction_n_i), .seen_sel_o(seen_sel),
		.seen_kind_o(seen_kind), .seen_pulse_o(seen_pulse),
		.got_word_o(got_word), .got_chan_o(got_chan)
	);

	// **********************************
	// Memory, compare and verdict
	// **********************************
	// Memory answers one cycle late with the inverted address.
	always @(posedge clock_i) begin
		mem_done_i <= mem_valid_o;
		mem_rdata_i <= ~mem_o.addr;
		if (mem_valid_o === 1'b1)
			mem_log.push_back(mem_o);
	end

	task automatic chk(input string name, input logic [15:0] exp, got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic results;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// **********************************
	// Scenarios
	// **********************************
	task automatic t_reset;
		@(negedge clock_i);
		chk("ready", 16'h1, {15'h0, cmd_ready_o});
		chk("rq_sync", 16'h1, {15'h0, request_sync_n_o});
		chk("ack", 16'h1, {15'h0, channel_ack_n_o});
		chk("strobes", 16'h0, {6'h0, din, dout, pulse, data_oe_o});
		$display("reset test done");
	endtask

	task automatic t_rqsync;
		int n, lo, hi;
		for (n = 0; n < 50 && request_sync_n_o !== 1'b1; n++) @(negedge clock_i);
		for (n = 0; n < 50 && request_sync_n_o !== 1'b0; n++) @(negedge clock_i);
		for (lo = 0; lo < 50 && request_sync_n_o === 1'b0; lo++) @(negedge clock_i);
		for (hi = 0; hi < 50 && request_sync_n_o === 1'b1; hi++) @(negedge clock_i);
		chk("rq_low", 16'd20, 16'(lo));
		chk("rq_high", 16'd20, 16'(hi));
		$display("request sync test done");
	endtask

	// Both directions, every buffer and every control code, back to back.
	task automatic t_pio;
		int n;
		logic [1:0] b, c;
		logic out;
		for (int i = 0; i < 6; i++) begin
			out = i[0];
			b = 2'(i % 3);
			c = 2'(i % 4);
			@(posedge clock_i);
			cmd_valid_i <= 1'b1;
			cmd_i <= '{out, b, c, 16'h6400 | {10'h0, DEV}, 16'h9E10 ^ {14'h0, b}};
			@(posedge clock_i);
			cmd_valid_i <= 1'b0;
			for (n = 0; n < 200 && pio_done_o !== 1'b1; n++) @(negedge clock_i);
			chk("pio_done", 16'h1, {15'h0, pio_done_o});
			chk("select", {10'h0, DEV}, {10'h0, seen_sel});
			chk("strobe", {12'h0, out, 3'h1 << b}, {12'h0, seen_kind});
			chk("pulse", c == 2'h0 ? 16'h0 : 16'h1 << (c - 2'h1),
				{13'h0, seen_pulse});
			if (out)
				chk("dout", 16'h9E10 ^ {14'h0, b}, got_word);
			else
				chk("din", 16'hC3A0 | {14'h0, b}, pio_rdata_o);
		end
		$display("programmed io test done");
	endtask

	task automatic t_irq;
		int n;
		mem_log.delete();
		@(posedge clock_i);
		want_irq <= 1'b1;
		pc_i <= 16'h3A7C;
		for (n = 0; n < 200 && irq_request_n_i !== 1'b0; n++) @(posedge clock_i);
		repeat (60) @(posedge clock_i);
		instr_end_soon_i <= 1'b1;
		@(posedge clock_i);
		instr_end_soon_i <= 1'b0;
		for (n = 0; n < 100 && irq_take_o !== 1'b1; n++) @(negedge clock_i);
		chk("irq_take", 16'h1, {15'h0, irq_take_o});
		want_irq <= 1'b0;
		for (n = 0; n < 300 && vector_valid_o !== 1'b1; n++) @(negedge clock_i);
		chk("entry_fast", 16'h1, {15'h0, n <= 120});
		chk("vector", 16'hFFFE, vector_o);
		chk("mem_count", 16'h2, 16'(mem_log.size()));
		chk("save", 16'h0000, mem_log[0].addr);
		chk("save_we", 16'h1, {15'h0, mem_log[0].we});
		chk("save_data", 16'h3A7C, mem_log[0].wdata);
		chk("fetch", 16'h0001, mem_log[1].addr);
		$display("interrupt test done");
	endtask

	task automatic t_chan(input logic out);
		int n;
		mem_log.delete();
		@(posedge clock_i);
		chan_out <= out;
		chan_word <= out ? 16'h0123 : 16'h0456;
		want_chan <= 1'b1;
		for (n = 0; n < 400 && channel_ack_n_o !== 1'b0; n++) @(negedge clock_i);
		chk("chan_ack", 16'h0, {15'h0, channel_ack_n_o});
		for (n = 0; n < 400 && (out ? cdout : cdin) !== 1'b1; n++)
			@(negedge clock_i);
		chk("chan_strobe", 16'h1, {15'h0, out ? cdout : cdin});
		want_chan <= 1'b0;
		repeat (200) @(negedge clock_i);
		chk("chan_addr", chan_word, mem_log[0].addr);
		chk("chan_we", {15'h0, !out}, {15'h0, mem_log[0].we});
		if (out)
			chk("chan_out", ~chan_word, got_chan);
		else
			chk("chan_in", ~chan_word, mem_log[0].wdata);
		$display("data channel test done");
	endtask

	task automatic t_selftest;
		for (int v = 0; v < 2; v++) begin
			@(posedge clock_i);
			selftest_select_n_i <= v[0];
			repeat (10) @(posedge clock_i);
			load_start_i <= 1'b1;
			@(posedge clock_i);
			load_start_i <= 1'b0;
			@(negedge clock_i);
			chk("selftest", {15'h0, !v[0]}, {15'h0, load_selftest_o});
		end
		$display("self test done");
	endtask

	initial begin
		repeat (4) @(posedge link_clk_i);
		t_reset;
		@(posedge clock_i);
		arst_n_i <= 1'b1;
		t_rqsync;
		t_pio;
		t_irq;
		t_chan(1'b0);
		t_chan(1'b1);
		t_selftest;
		results();
	end

	// Whole run needs about 1500 cycles; this leaves wide margin.
	initial begin
		repeat (20000) @(posedge clock_i);
		fail_count++;
		$display("[ERR] watchdog expected finish seen hang");
		results();
	end
endmodule
